/* hdl/psa_regs.svh */
// Constants of the packed integer SIMD datapath
`ifndef PSA_REGS_SVH
`define PSA_REGS_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define PSA_REG_W      128
`define PSA_CHUNK_W    64
`define PSA_CHUNKS     2
`define PSA_IMM_W      8
`define PSA_OP_W       4

// ------------------------------------------------------------
// Lane counts per chunk
// ------------------------------------------------------------
`define PSA_WORDS      4
`define PSA_BYTES      8
`define PSA_DWORDS     2

// ------------------------------------------------------------
// Shift limits and latency
// ------------------------------------------------------------
`define PSA_SHIFT_MAX  8'h0f
`define PSA_LATENCY    2

`endif

/* hdl/psa_pkg.sv */
// Types of the packed integer SIMD datapath
`default_nettype none
`include "psa_regs.svh"

package psa_pkg;

   // ------------------------------------------------------------
   // Operation select
   // ------------------------------------------------------------
   typedef enum logic [`PSA_OP_W-1:0] {
      OP_SIGNED_WORD_MAX,
      OP_SIGNED_WORD_MIN,
      OP_UNSIGNED_BYTE_MAX,
      OP_UNSIGNED_BYTE_MIN,
      OP_UNSIGNED_WORD_MUL_HIGH,
      OP_SIGNED_WORD_MUL_HIGH,
      OP_BYTE_ABS_DIFF_SUM,
      OP_BYTE_ROUND_AVERAGE,
      OP_WORD_ROUND_AVERAGE,
      OP_WORD_MUL_ADD,
      OP_DWORD_TO_QWORD_MUL,
      OP_QWORD_ADD,
      OP_QWORD_SUB,
      OP_REG_BYTE_SHIFT_LEFT,
      OP_REG_BYTE_SHIFT_RIGHT
   } psa_op_t;

   // ------------------------------------------------------------
   // Request and response
   // ------------------------------------------------------------
   typedef struct packed {
      logic                   valid;
      psa_op_t                op;
      logic                   wide;
      logic                   src_mem;
      logic [`PSA_IMM_W-1:0]  imm;
      logic [`PSA_REG_W-1:0]  a;
      logic [`PSA_REG_W-1:0]  b_reg;
      logic [`PSA_REG_W-1:0]  b_mem;
   } psa_req_t;

   typedef struct packed {
      logic                   valid;
      logic [`PSA_REG_W-1:0]  data;
   } psa_rsp_t;

endpackage

`default_nettype wire

/* hdl/psa_mul_chunk.sv */
// Word and doubleword multipliers for one 64-bit chunk
`default_nettype none
`include "psa_regs.svh"

module psa_mul_chunk
   import psa_pkg::*;
(
   // Operands
   input  wire logic [`PSA_CHUNK_W-1:0] a,
   input  wire logic [`PSA_CHUNK_W-1:0] b,
   // Results
   output logic      [`PSA_CHUNK_W-1:0] hi_u,
   output logic      [`PSA_CHUNK_W-1:0] hi_s,
   output logic      [`PSA_CHUNK_W-1:0] madd,
   output logic      [`PSA_CHUNK_W-1:0] mudq
);

   logic signed [31:0] prod_s [`PSA_WORDS];

   // ------------------------------------------------------------
   // Word lanes
   // ------------------------------------------------------------
   for (genvar w = 0; w < `PSA_WORDS; w++) begin : g_word
      logic [31:0] prod_u;
      assign prod_u    = a[16*w +: 16] * b[16*w +: 16];
      assign prod_s[w] = $signed(a[16*w +: 16]) * $signed(b[16*w +: 16]);
      assign hi_u[16*w +: 16] = prod_u[31:16];     // RULE5 RULE6
      assign hi_s[16*w +: 16] = prod_s[w][31:16];  // RULE5 RULE6
   end

   // ------------------------------------------------------------
   // Pairwise multiply-add
   // ------------------------------------------------------------
   for (genvar d = 0; d < `PSA_DWORDS; d++) begin : g_dword
      logic [31:0] pair_sum;
      assign pair_sum = 32'(prod_s[2*d] + prod_s[2*d+1]);  // RULE13
      assign madd[32*d +: 32] = pair_sum;                  // RULE14
   end

   // ------------------------------------------------------------
   // Low doubleword full product
   // ------------------------------------------------------------
   assign mudq = 64'(a[31:0]) * 64'(b[31:0]);  // RULE15

endmodule

`default_nettype wire

/* hdl/psa_byte_shift.sv */
// Whole-register byte shift by an immediate count
`default_nettype none
`include "psa_regs.svh"

module psa_byte_shift
   import psa_pkg::*;
(
   // Operand
   input  wire logic [`PSA_REG_W-1:0] data,
   input  wire logic [`PSA_IMM_W-1:0] imm,
   input  wire logic                  left,
   // Result
   output logic      [`PSA_REG_W-1:0] result
);

   logic [6:0] bit_amt;

   assign bit_amt = {imm[3:0], 3'h0};

   always_comb begin
      if (imm > `PSA_SHIFT_MAX) begin
         result = '0;                    // RULE21
      end else if (left) begin
         result = data << bit_amt;       // RULE20
      end else begin
         result = data >> bit_amt;       // RULE20
      end
   end

endmodule

`default_nettype wire

/* hdl/psa_alu.sv */
// Packed integer SIMD arithmetic datapath, two-stage pipeline
`default_nettype none
`include "psa_regs.svh"

// Summary of operation
// RULE1: Signed word max: four signed 16-bit lanes, larger per lane.
// RULE2: Signed word min: four signed 16-bit lanes, smaller per lane.
// RULE3: Unsigned byte max: eight unsigned byte lanes, larger per lane.
// RULE4: Unsigned byte min: eight unsigned byte lanes, smaller per lane.
// RULE5: Word multiply high keeps bits 31..16 of each 32-bit product.
// RULE6: Multiply high has unsigned and signed variants.
// RULE7: Byte absolute differences summed into the lowest 16-bit field.
// RULE8: After the difference sum the upper three words are zero.
// RULE9: Average adds elements plus one, shifts each sum right one bit.
// RULE10: The average keeps the carry-out as the element's top bit.
// RULE11: Average exists for unsigned bytes and unsigned words.
// RULE12: Destination is a register; second operand from register or memory.
// RULE13: Multiply-add: four word products per chunk, adjacent pairs summed.
// RULE14: Multiply-add result is two 32-bit doublewords per chunk.
// RULE15: Low unsigned doublewords multiplied into a full 64-bit product.
// RULE16: Doubleword multiply in 64 and 128-bit forms, one per half.
// RULE17: Quadword add and subtract give a 64-bit result per chunk.
// RULE18: Quadword add and subtract wrap modulo two to the 64th.
// RULE19: Quadword add and subtract in 64 and 128-bit forms.
// RULE20: Byte shifts move left or right by immediate bytes, zero filled.
// RULE21: A byte shift count above 15 gives all zeros.
// RULE22: Op code with operands in; full result at fixed latency, no flags.
module psa_alu
   import psa_pkg::*;
(
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      arst_n,
   // Request from issue
   input  wire psa_req_t  req,
   // Result to destination register
   output var  psa_rsp_t  rsp
);

   // ------------------------------------------------------------
   // Input stage
   // ------------------------------------------------------------
   psa_req_t req_d;
   psa_req_t req_q;

   always_comb begin
      req_d = req;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // ------------------------------------------------------------
   // Operand select
   // ------------------------------------------------------------
   logic [`PSA_REG_W-1:0] opa;
   logic [`PSA_REG_W-1:0] opb;

   always_comb begin
      opa = req_q.a;
      if (req_q.src_mem) begin
         opb = req_q.b_mem;                              // RULE12
      end else begin
         opb = req_q.b_reg;                              // RULE12
      end
   end

   // ------------------------------------------------------------
   // Operation class decode
   // ------------------------------------------------------------
   logic op_is_shift;
   logic op_shift_left;
   logic op_is_known;
   logic op_is_narrow;

   always_comb begin
      op_is_shift   = 1'b0;
      op_shift_left = 1'b0;
      op_is_known   = 1'b1;
      case (req_q.op)
         OP_SIGNED_WORD_MAX,
         OP_SIGNED_WORD_MIN,
         OP_UNSIGNED_BYTE_MAX,
         OP_UNSIGNED_BYTE_MIN,
         OP_UNSIGNED_WORD_MUL_HIGH,
         OP_SIGNED_WORD_MUL_HIGH,
         OP_BYTE_ABS_DIFF_SUM,
         OP_BYTE_ROUND_AVERAGE,
         OP_WORD_ROUND_AVERAGE,
         OP_WORD_MUL_ADD,
         OP_DWORD_TO_QWORD_MUL,
         OP_QWORD_ADD,
         OP_QWORD_SUB: begin
            op_is_shift = 1'b0;
         end
         OP_REG_BYTE_SHIFT_LEFT: begin
            op_is_shift   = 1'b1;                        // RULE20
            op_shift_left = 1'b1;                        // RULE20
         end
         OP_REG_BYTE_SHIFT_RIGHT: begin
            op_is_shift = 1'b1;                          // RULE20
         end
         default: begin
            op_is_known = 1'b0;                          // RULE22
         end
      endcase
   end

   assign op_is_narrow = !req_q.wide && !op_is_shift;   // RULE16 RULE19

   // ------------------------------------------------------------
   // Per-chunk results
   // ------------------------------------------------------------
   logic [`PSA_CHUNK_W-1:0] smax_w [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] smin_w [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] umax_b [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] umin_b [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] avg_b  [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] avg_w  [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] sad_r  [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] add_q  [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] sub_q  [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] mhi_u  [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] mhi_s  [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] madd   [`PSA_CHUNKS];
   logic [`PSA_CHUNK_W-1:0] mudq   [`PSA_CHUNKS];

   for (genvar c = 0; c < `PSA_CHUNKS; c++) begin : g_chunk
      logic [`PSA_CHUNK_W-1:0] ca;
      logic [`PSA_CHUNK_W-1:0] cb;
      logic [7:0]              diff [`PSA_BYTES];
      logic [15:0]             sad_sum;

      assign ca = opa[`PSA_CHUNK_W*c +: `PSA_CHUNK_W];
      assign cb = opb[`PSA_CHUNK_W*c +: `PSA_CHUNK_W];

      // ---------------------------------------------------------
      // Word lanes
      // ---------------------------------------------------------
      for (genvar w = 0; w < `PSA_WORDS; w++) begin : g_word
         logic [15:0] wa;
         logic [15:0] wb;
         logic        a_gt;
         logic [16:0] wsum;
         logic        wcarry;

         assign wa   = ca[16*w +: 16];
         assign wb   = cb[16*w +: 16];
         assign a_gt = $signed(wa) > $signed(wb);
         assign smax_w[c][16*w +: 16] = a_gt ? wa : wb;  // RULE1
         assign smin_w[c][16*w +: 16] = a_gt ? wb : wa;  // RULE2
         assign wsum = 17'(wa) + 17'(wb) + 17'h00001;    // RULE9 RULE11
         assign wcarry = wsum[16];                       // RULE10
         assign avg_w[c][16*w +: 16] = {wcarry, wsum[15:1]};  // RULE10
      end

      // ---------------------------------------------------------
      // Byte lanes
      // ---------------------------------------------------------
      for (genvar b = 0; b < `PSA_BYTES; b++) begin : g_byte
         logic [7:0] ba;
         logic [7:0] bb;
         logic       a_gt;
         logic [8:0] bsum;
         logic       bcarry;

         assign ba   = ca[8*b +: 8];
         assign bb   = cb[8*b +: 8];
         assign a_gt = ba > bb;
         assign umax_b[c][8*b +: 8] = a_gt ? ba : bb;    // RULE3
         assign umin_b[c][8*b +: 8] = a_gt ? bb : ba;    // RULE4
         assign diff[b] = a_gt ? 8'(ba - bb) : 8'(bb - ba);  // RULE7
         assign bsum = 9'(ba) + 9'(bb) + 9'h001;         // RULE9 RULE11
         assign bcarry = bsum[8];                        // RULE10
         assign avg_b[c][8*b +: 8] = {bcarry, bsum[7:1]};  // RULE10
      end

      // ---------------------------------------------------------
      // Sum of absolute differences
      // ---------------------------------------------------------
      logic [8:0]  sad_l1 [4];
      logic [9:0]  sad_l2 [2];
      logic [10:0] sad_l3;

      for (genvar i = 0; i < 4; i++) begin : g_sad_l1
         assign sad_l1[i] = 9'(diff[2*i]) + 9'(diff[2*i+1]);          // RULE7
      end

      for (genvar i = 0; i < 2; i++) begin : g_sad_l2
         assign sad_l2[i] = 10'(sad_l1[2*i]) + 10'(sad_l1[2*i+1]);    // RULE7
      end

      assign sad_l3  = 11'(sad_l2[0]) + 11'(sad_l2[1]);   // RULE7
      assign sad_sum = 16'(sad_l3);                       // RULE7

      assign sad_r[c] = {48'h0, sad_sum};                // RULE8

      // ---------------------------------------------------------
      // Quadword add and subtract
      // ---------------------------------------------------------
      assign add_q[c] = 64'(ca + cb);                    // RULE17 RULE18
      assign sub_q[c] = 64'(ca - cb);                    // RULE17 RULE18

      // ---------------------------------------------------------
      // Multipliers
      // ---------------------------------------------------------
      psa_mul_chunk u_mul (
         .a    (ca),
         .b    (cb),
         .hi_u (mhi_u[c]),
         .hi_s (mhi_s[c]),
         .madd (madd[c]),
         .mudq (mudq[c])
      );
   end

   // ------------------------------------------------------------
   // Whole-register byte shift
   // ------------------------------------------------------------
   logic [`PSA_REG_W-1:0] shift_r;

   psa_byte_shift u_shift (
      .data   (opa),
      .imm    (req_q.imm),
      .left   (op_shift_left),
      .result (shift_r)
   );

   // ------------------------------------------------------------
   // Result select
   // ------------------------------------------------------------
   logic [`PSA_CHUNK_W-1:0] chunk_r [`PSA_CHUNKS];
   logic [`PSA_REG_W-1:0]   result;

   for (genvar c = 0; c < `PSA_CHUNKS; c++) begin : g_sel
      always_comb begin
         case (req_q.op)
            OP_SIGNED_WORD_MAX:        chunk_r[c] = smax_w[c];  // RULE1
            OP_SIGNED_WORD_MIN:        chunk_r[c] = smin_w[c];  // RULE2
            OP_UNSIGNED_BYTE_MAX:      chunk_r[c] = umax_b[c];  // RULE3
            OP_UNSIGNED_BYTE_MIN:      chunk_r[c] = umin_b[c];  // RULE4
            OP_UNSIGNED_WORD_MUL_HIGH: chunk_r[c] = mhi_u[c];   // RULE6
            OP_SIGNED_WORD_MUL_HIGH:   chunk_r[c] = mhi_s[c];   // RULE6
            OP_BYTE_ABS_DIFF_SUM:      chunk_r[c] = sad_r[c];   // RULE8
            OP_BYTE_ROUND_AVERAGE:     chunk_r[c] = avg_b[c];   // RULE11
            OP_WORD_ROUND_AVERAGE:     chunk_r[c] = avg_w[c];   // RULE11
            OP_WORD_MUL_ADD:           chunk_r[c] = madd[c];    // RULE14
            OP_DWORD_TO_QWORD_MUL:     chunk_r[c] = mudq[c];    // RULE16
            OP_QWORD_ADD:              chunk_r[c] = add_q[c];   // RULE19
            OP_QWORD_SUB:              chunk_r[c] = sub_q[c];   // RULE19
            OP_REG_BYTE_SHIFT_LEFT,
            OP_REG_BYTE_SHIFT_RIGHT: begin
               chunk_r[c] = shift_r[`PSA_CHUNK_W*c +: `PSA_CHUNK_W];  // RULE20
            end
            default:                   chunk_r[c] = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Narrow form clears the upper half except for byte shifts; unknown codes give zero
   // ------------------------------------------------------------
   always_comb begin
      result = {chunk_r[1], chunk_r[0]};
      if (op_is_narrow) begin
         result[`PSA_REG_W-1:`PSA_CHUNK_W] = '0;           // RULE16 RULE19
      end
      if (!op_is_known) begin
         result = '0;                                       // RULE22
      end
   end

   // ------------------------------------------------------------
   // Output stage
   // ------------------------------------------------------------
   psa_rsp_t rsp_d;
   psa_rsp_t rsp_q;

   always_comb begin
      rsp_d = '0;
      if (req_q.valid) begin
         rsp_d.valid = 1'b1;                             // RULE22
         rsp_d.data  = result;                           // RULE22
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   assign rsp = rsp_q;

endmodule

`default_nettype wire

/* testbench/psa_alu_chk.sv */
// Assertion checker for the packed SIMD datapath ports
`default_nettype none

module psa_alu_chk
   import psa_pkg::*;
(
   // Clock and reset
   input wire logic     clk,
   input wire logic     arst_n,
   // Datapath ports
   input wire psa_req_t req,
   input wire psa_rsp_t rsp
);
   // ----------------------------------------
   // Request delayed to line up with rsp
   // ----------------------------------------
   psa_req_t    pipe_q [2];
   psa_req_t    pipe_d [2];
   psa_req_t    p;
   logic [63:0] b2;

   always_comb begin
      pipe_d = '{req, pipe_q[0]};
      p      = pipe_q[1];
      b2     = p.src_mem ? p.b_mem[63:0] : p.b_reg[63:0];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pipe_q <= '{default: '0};
      end else begin
         pipe_q <= pipe_d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   fixed_lat_a: assert property (req.valid |-> ##2 rsp.valid)
      else $error("result missing two edges after request");
   one_pulse_a: assert property (req.valid ##1 !req.valid |-> ##1 rsp.valid ##1 !rsp.valid)
      else $error("result not a single pulse");
   no_spur_a: assert property (rsp.valid |-> p.valid)
      else $error("result without request");
   idle_zero_a: assert property (!rsp.valid |-> rsp.data == '0)
      else $error("data not zero while idle");
   qword_add_a: assert property (p.valid && p.op == OP_QWORD_ADD |-> rsp.data[63:0] == p.a[63:0] + b2)
      else $error("quadword add wrong");
   qword_sub_a: assert property (p.valid && p.op == OP_QWORD_SUB |-> rsp.data[63:0] == p.a[63:0] - b2)
      else $error("quadword sub wrong");
   narrow_zero_a: assert property (p.valid && !p.wide && p.op < OP_REG_BYTE_SHIFT_LEFT |->
      rsp.data[127:64] == '0)
      else $error("narrow form upper half not zero");
   sad_upper_a: assert property (p.valid && p.op == OP_BYTE_ABS_DIFF_SUM |->
      rsp.data[63:16] == '0 && rsp.data[127:80] == '0)
      else $error("difference sum upper words not zero");
   shift_over_a: assert property (p.valid && p.op inside {OP_REG_BYTE_SHIFT_LEFT, OP_REG_BYTE_SHIFT_RIGHT}
      && p.imm > 8'h0f |-> rsp.data == '0)
      else $error("oversized shift not zero");
   dword_mul_a: assert property (p.valid && p.op == OP_DWORD_TO_QWORD_MUL |->
      rsp.data[63:0] == {32'h0, p.a[31:0]} * {32'h0, b2[31:0]})
      else $error("doubleword multiply wrong");
endmodule

bind psa_alu psa_alu_chk u_psa_alu_chk (.clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp));

`default_nettype wire

/* testbench/psa_issue_model.sv */
// Issue logic and register file model feeding the datapath
`default_nettype none

module psa_issue_model
   import psa_pkg::*;
(
   // Clock
   input  wire logic     clk,
   // Request to datapath
   output var  psa_req_t req
);
   initial req = '0;

   // One request for one cycle, then valid dropped and operands inverted
   task automatic issue(input psa_op_t op, input logic wide, src_mem, input logic [7:0] imm,
                        input logic [127:0] a, b);
      @(negedge clk);
      req.valid   = 1'b1;
      req.op      = op;
      req.wide    = wide;
      req.src_mem = src_mem;
      req.imm     = imm;
      req.a       = a;
      req.b_reg   = src_mem ? ~b : b;
      req.b_mem   = src_mem ? b : ~b;
      @(negedge clk);
      req.valid   = 1'b0;
      req.a       = ~req.a;
      req.b_reg   = ~req.b_reg;
      req.b_mem   = ~req.b_mem;
   endtask
endmodule

`default_nettype wire

/* testbench/test_packed_integer_simd_alu.sv */
// Self-checking bench for the packed SIMD datapath
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module test_packed_integer_simd_alu
   import psa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic     clk;
   logic     arst_n;
   psa_req_t req;
   psa_rsp_t rsp;
   int       err_count;
   int       tests_run;

   localparam logic [127:0] OPA = 128'h8000_7fff_fffe_0003_ff00_80c0_7f01_0203;
   localparam logic [127:0] OPB = 128'h7fff_8000_0002_fffd_00ff_7f40_8102_0301;
   localparam logic [127:0] OPC = 128'hffff_ffff_ffff_ffff_8000_8000_ffff_ffff;
   localparam logic [127:0] OPD = 128'h0000_0000_0000_0001_8000_8000_ffff_ffff;

   psa_issue_model u_psa_issue_model (.clk(clk), .req(req));
   psa_alu u_psa_alu (.clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------
   // Expected result
   // ----------------------------------------
   function automatic logic [127:0] ref_f(int op, logic w, logic [7:0] imm, logic [127:0] a, b);
      logic [127:0]       r;
      logic [63:0]        x, y, z;
      logic signed [31:0] p;
      int                 s;
      r = '0;
      for (int c = 0; c < 2; c++) begin
         x = a[64*c+:64];
         y = b[64*c+:64];
         z = '0;
         s = 0;
         for (int i = 0; i < 8; i++) begin
            case (op)
               2: z[8*i+:8] = x[8*i+:8] > y[8*i+:8] ? x[8*i+:8] : y[8*i+:8];
               3: z[8*i+:8] = x[8*i+:8] < y[8*i+:8] ? x[8*i+:8] : y[8*i+:8];
               6: s += x[8*i+:8] > y[8*i+:8] ? x[8*i+:8] - y[8*i+:8] : y[8*i+:8] - x[8*i+:8];
               7: z[8*i+:8] = (int'(x[8*i+:8]) + int'(y[8*i+:8]) + 1) >> 1;
               default: ;
            endcase
            if (i < 4) begin
               p = $signed(x[16*i+:16]) * $signed(y[16*i+:16]);
               case (op)
                  0: z[16*i+:16] = $signed(x[16*i+:16]) > $signed(y[16*i+:16]) ? x[16*i+:16] : y[16*i+:16];
                  1: z[16*i+:16] = $signed(x[16*i+:16]) < $signed(y[16*i+:16]) ? x[16*i+:16] : y[16*i+:16];
                  4: z[16*i+:16] = (32'(x[16*i+:16]) * 32'(y[16*i+:16])) >> 16;
                  5: z[16*i+:16] = p[31:16];
                  8: z[16*i+:16] = (int'(x[16*i+:16]) + int'(y[16*i+:16]) + 1) >> 1;
                  9: z[32*(i/2)+:32] += p;
                  default: ;
               endcase
            end
         end
         case (op)
            6: z = 64'(s);
            10: z = 64'(x[31:0]) * 64'(y[31:0]);
            11: z = x + y;
            12: z = x - y;
            default: ;
         endcase
         r[64*c+:64] = z;
      end
      if (!w) r[127:64] = '0;
      if (op == 13) r = imm > 8'h0f ? '0 : a << (8 * imm);
      if (op == 14) r = imm > 8'h0f ? '0 : a >> (8 * imm);
      return r;
   endfunction

   // ----------------------------------------
   // One operation, answer and idle after
   // ----------------------------------------
   task automatic run(input int op, input logic w, m, input logic [7:0] imm, input logic [127:0] a, b);
      logic [127:0] e;
      e = ref_f(op, w, imm, a, b);
      u_psa_issue_model.issue(psa_op_t'(op), w, m, imm, a, b);
      @(negedge clk);
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.data, e)
      @(negedge clk);
      `CHK(rsp, '0)
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_lanes;
      for (int op = 0; op < 16; op++) run(op, 1'b1, 1'b0, 8'h00, OPA, OPB);
      $display("lanes done");
   endtask

   task automatic t_memsrc;
      for (int op = 0; op < 13; op++) run(op, 1'b0, 1'b1, 8'h00, OPB, OPA);
      $display("memory source done");
   endtask

   task automatic t_corner;
      for (int op = 0; op < 13; op++) run(op, 1'b1, 1'b1, 8'h00, OPC, OPD);
      $display("corner values done");
   endtask

   task automatic t_shift;
      logic [7:0] cnt [6] = '{8'h00, 8'h01, 8'h07, 8'h0f, 8'h10, 8'hff};
      foreach (cnt[k]) begin
         run(13, cnt[k][0], 1'b0, cnt[k], OPA, OPB);
         run(14, cnt[k][1], 1'b0, cnt[k], OPA, OPB);
      end
      $display("byte shifts done");
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      complete_run;
   end

   initial begin
      err_count = 0;
      tests_run = 0;
      arst_n    = 1'b0;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      t_lanes;
      t_memsrc;
      t_corner;
      t_shift;
      complete_run;
   end
endmodule

`default_nettype wire
